// [core/smpc_params.svh]
// constants for the stop-mode power controller
// assumes inclusion by bare name from core files
`ifndef SMPC_PARAMS_SVH
`define SMPC_PARAMS_SVH
`define SMPC_CLK_PERIOD_PS     5000
`define SMPC_OSC_SETTLE_NS     1000
`define SMPC_OSC_SETTLE_CYC    ((`SMPC_OSC_SETTLE_NS * 1000 + `SMPC_CLK_PERIOD_PS - 1) / `SMPC_CLK_PERIOD_PS)
`define SMPC_SETTLE_W          8
`define SMPC_PERIPH_W          8
`define SMPC_PERIPH_RST        8'hFF
`define SMPC_OSC_EN_RST        1'b1
`define SMPC_PINS_EN_RST       1'b0
`define SMPC_CLK_EN_RST        1'b1
`define SMPC_HALT_RST          1'b0
`define SMPC_WDT_RST           1'b0
`define SMPC_BO_EN_RST         1'b1
`define SMPC_STOP_RST          1'b0
`endif

// [core/smpc_pkg.sv]
// types for the stop-mode power controller
// assumes smpc_params.svh is available
package smpc_pkg;
   typedef enum logic [3:0] {
      SMPC_RUN    = 4'h1,
      SMPC_STOP   = 4'h2,
      SMPC_WAKE   = 4'h4,
      SMPC_SETTLE = 4'h8
   } smpc_state_t;
endpackage : smpc_pkg

// [core/smpc_sync_if.sv]
// carrier between the controller and its pin synchroniser
// assumes a single clock domain
`timescale 1ns/1ps
interface smpc_sync_if;
   logic raw_wake;
   logic raw_osc_ok;
   logic wake;
   logic osc_ok;
   modport sync (input raw_wake, input raw_osc_ok, output wake, output osc_ok);
   modport ctrl (output raw_wake, output raw_osc_ok, input wake, input osc_ok);
endinterface : smpc_sync_if

// [core/smpc_sync.sv]
// two-stage synchroniser for the asynchronous pins
// assumes synchronous active-high reset
`timescale 1ns/1ps
module smpc_sync
   import smpc_pkg::*;
(
   input  wire logic core_clk_in,
   input  wire logic sys_rst_in,
   smpc_sync_if.sync sif
);
   logic [1:0] meta_ff;
   logic [1:0] sync_ff;

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         meta_ff <= 2'h0;
         sync_ff <= 2'h0;
      end
      else
      begin
         meta_ff <= {sif.raw_osc_ok, sif.raw_wake};
         sync_ff <= meta_ff;
      end
   end

   assign sif.wake   = sync_ff[0];
   assign sif.osc_ok = sync_ff[1];
endmodule : smpc_sync

// [core/smpc_ctrl.sv]
// stop-mode power controller: oscillator, clock, core and peripheral gating
// assumes core_clk_in is an always-on control clock; stop_exec_in from core logic
//
// Overview of operation
// - stop instruction moves device into the deepest low-power state.
// - stop state turns off crystal and precision oscillators.
// - stop state releases crystal pins to general-purpose port control.
// - system clock gated off throughout the stop state.
// - processor halted, program counter does not advance while stopped.
// - watchdog oscillator keeps running in stop only when enabled.
// - watchdog logic keeps counting in stop when enabled, own clock.
// - brown-out protection runs in stop only if option bit allows.
// - all other peripherals held idle during stop.
// - only stop-mode recovery leaves the stop state.
// - peripherals individually disabled while running normally.
`timescale 1ns/1ps
`include "smpc_params.svh"
module smpc_ctrl
   import smpc_pkg::*;
(
   input  wire logic                      core_clk_in,
   input  wire logic                      sys_rst_in,
   input  wire logic                      stop_exec_in,
   input  wire logic                      stop_recovery_in,
   input  wire logic                      osc_stable_in,
   input  wire logic                      xtal_pins_en_in,
   input  wire logic                      wdt_osc_en_in,
   input  wire logic                      wdt_en_in,
   input  wire logic                      bo_stop_opt_in,
   input  wire logic [`SMPC_PERIPH_W-1:0] periph_en_in,
   output logic                           primary_osc_en_out,
   output logic                           precision_osc_en_out,
   output logic                           crystal_pins_en_out,
   output logic                           sys_clk_en_out,
   output logic                           cpu_halt_out,
   output logic                           program_counter_hold_out,
   output logic                           watchdog_osc_en_out,
   output logic                           watchdog_unit_run_out,
   output logic                           brownout_protection_en_out,
   output logic [`SMPC_PERIPH_W-1:0]      periph_clk_en_out,
   output logic                           in_stop_out
);
   smpc_sync_if sif ();
   smpc_state_t state_ff;
   smpc_state_t nxt_state;
   logic [`SMPC_SETTLE_W-1:0] settle_ff;
   logic                      nxt_run;
   logic                      nxt_stop;

   assign sif.raw_wake   = stop_recovery_in;
   assign sif.raw_osc_ok = osc_stable_in;

   smpc_sync u_sync (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .sif         (sif)
   );

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         SMPC_RUN:    if (stop_exec_in) nxt_state = SMPC_STOP;
         SMPC_STOP:   if (sif.wake) nxt_state = SMPC_WAKE;
         SMPC_WAKE:   if (sif.osc_ok) nxt_state = SMPC_SETTLE;
         SMPC_SETTLE: if (settle_ff == `SMPC_SETTLE_W'(`SMPC_OSC_SETTLE_CYC - 1))
                         nxt_state = SMPC_RUN;
         default:     nxt_state = SMPC_RUN;
      endcase
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         state_ff <= SMPC_RUN;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         settle_ff <= '0;
      else if (state_ff == SMPC_SETTLE)
         settle_ff <= settle_ff + `SMPC_SETTLE_W'(1);
      else
         settle_ff <= '0;
   end

   // gating follows next state so outputs change on the taking edge
   always_comb
   begin
      nxt_run  = (nxt_state == SMPC_RUN);
      nxt_stop = (nxt_state == SMPC_STOP);
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         primary_osc_en_out <= `SMPC_OSC_EN_RST;
      end
      else
      begin
         primary_osc_en_out <= !nxt_stop;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         precision_osc_en_out <= `SMPC_OSC_EN_RST;
      end
      else
      begin
         precision_osc_en_out <= !nxt_stop;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         crystal_pins_en_out <= `SMPC_PINS_EN_RST;
      end
      else
      begin
         crystal_pins_en_out <= xtal_pins_en_in && !nxt_stop;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         sys_clk_en_out <= `SMPC_CLK_EN_RST;
      end
      else
      begin
         sys_clk_en_out <= nxt_run;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         cpu_halt_out <= `SMPC_HALT_RST;
      end
      else
      begin
         cpu_halt_out <= !nxt_run;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         program_counter_hold_out <= `SMPC_HALT_RST;
      end
      else
      begin
         program_counter_hold_out <= !nxt_run;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         watchdog_osc_en_out <= `SMPC_WDT_RST;
      end
      else
      begin
         watchdog_osc_en_out <= wdt_osc_en_in;
      end
   end

   // watchdog on own clock
   // needs its oscillator, since the system clock may be stopped
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         watchdog_unit_run_out <= `SMPC_WDT_RST;
      end
      else
      begin
         watchdog_unit_run_out <= wdt_en_in && wdt_osc_en_in;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         brownout_protection_en_out <= `SMPC_BO_EN_RST;
      end
      else
      begin
         brownout_protection_en_out <= nxt_run || bo_stop_opt_in;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         periph_clk_en_out <= `SMPC_PERIPH_RST;
      end
      else
      begin
         periph_clk_en_out <= nxt_run ? periph_en_in : `SMPC_PERIPH_W'(0);
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         in_stop_out <= `SMPC_STOP_RST;
      end
      else
      begin
         in_stop_out <= !nxt_run;
      end
   end
endmodule : smpc_ctrl

// [tb/smpc_asserts.sv]
// port assertions for the stop-mode controller
// assumes bind onto smpc_ctrl, one clock
`timescale 1ns/1ps
`include "smpc_params.svh"
module smpc_asserts (
   input wire logic core_clk_in, sys_rst_in, stop_exec_in, in_stop_out, sys_clk_en_out,
   input wire logic cpu_halt_out, program_counter_hold_out, primary_osc_en_out,
   input wire logic precision_osc_en_out, crystal_pins_en_out, wdt_osc_en_in, wdt_en_in,
   input wire logic watchdog_osc_en_out, watchdog_unit_run_out, bo_stop_opt_in,
   input wire logic brownout_protection_en_out,
   input wire logic [`SMPC_PERIPH_W-1:0] periph_en_in, periph_clk_en_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_stop_entry: assert property (!in_stop_out && stop_exec_in |=> in_stop_out
      && cpu_halt_out) else $error("stop not entered");
   a_osc_off: assert property ($rose(in_stop_out) |-> !primary_osc_en_out
      && !precision_osc_en_out && !crystal_pins_en_out) else $error("osc left on");
   a_clk_held: assert property (in_stop_out |-> !sys_clk_en_out
      && program_counter_hold_out) else $error("clock runs in stop");
   a_periph_idle: assert property (in_stop_out |-> periph_clk_en_out == 0)
      else $error("peripheral active in stop");
   a_wdt_osc: assert property (!$past(sys_rst_in) |->
      watchdog_osc_en_out == $past(wdt_osc_en_in)) else $error("wdt osc");
   a_wdt_run: assert property (!$past(sys_rst_in) |->
      watchdog_unit_run_out == $past(wdt_en_in && wdt_osc_en_in)) else $error("wdt run");
   a_bo_stop: assert property (in_stop_out && $past(in_stop_out, 2) &&
      $stable(bo_stop_opt_in) |-> brownout_protection_en_out == bo_stop_opt_in)
      else $error("brownout");
   a_stop_held: assert property (in_stop_out && !primary_osc_en_out |=> in_stop_out)
      else $error("left stop early");
   a_run_periph: assert property (!in_stop_out && !$past(in_stop_out) &&
      !$past(sys_rst_in) |-> periph_clk_en_out == $past(periph_en_in)) else $error("periph");
   a_settle_wait: assert property ($rose(sys_clk_en_out) |->
      $past(primary_osc_en_out, 200)) else $error("clock before settle");
   cover property ($rose(in_stop_out));
   cover property ($fell(in_stop_out));
   cover property (in_stop_out && watchdog_unit_run_out);
endmodule : smpc_asserts
bind smpc_ctrl smpc_asserts u_chk (.*);

// [tb/smpc_core_model.sv]
// processor core model issuing the stop instruction
// assumes requests move on the falling edge
`timescale 1ns/1ps
module smpc_core_model (
   input  wire logic clk_in,
   input  wire logic go_in,
   input  wire logic halt_in,
   output logic      stop_exec_out = 1'b0
);
   always @(negedge clk_in) stop_exec_out <= go_in & ~halt_in;
endmodule : smpc_core_model

// [tb/tb_stop_mode_power_control.sv]
// bench: core model drives stop, bench drives recovery and options
// assumes smpc_ctrl, checker and core model compiled first
`timescale 1ns/1ps
`include "smpc_params.svh"
module tb_stop_mode_power_control;
   logic core_clk_in = 0, sys_rst_in = 1, go = 0, stop_recovery_in = 0, osc_stable_in = 0;
   logic xtal_pins_en_in = 1, wdt_osc_en_in = 0, wdt_en_in = 0, bo_stop_opt_in = 0;
   logic [7:0] periph_en_in = 0, periph_clk_en_out;
   logic primary_osc_en_out, precision_osc_en_out, crystal_pins_en_out, sys_clk_en_out;
   logic cpu_halt_out, program_counter_hold_out, watchdog_osc_en_out, stop_exec_in;
   logic watchdog_unit_run_out, brownout_protection_en_out, in_stop_out;
   int n_errors = 0, tests_run = 0, cyc = 0, w;
   always #2.5 core_clk_in = ~core_clk_in;
   smpc_core_model core (.clk_in(core_clk_in), .go_in(go), .halt_in(cpu_halt_out),
      .stop_exec_out(stop_exec_in));
   smpc_ctrl DUT (.*);
   task chk(string s, logic [7:0] v, logic [7:0] e);
      tests_run++;
      if (v !== e) begin n_errors++; $display("ERROR %s exp %h seen %h", s, e, v); end
   endtask : chk
   task final_report();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   always @(posedge core_clk_in) if (++cyc == 5000) begin n_errors++; final_report(); end
   initial
   begin
      w = $urandom(50);
      repeat (12) @(negedge core_clk_in);
      sys_rst_in <= 0;
      repeat (3)
      begin
         periph_en_in <= 8'($urandom);
         wdt_osc_en_in <= 1'($urandom);
         bo_stop_opt_in <= 1'($urandom);
         xtal_pins_en_in <= 1'($urandom);
         repeat (2) @(negedge core_clk_in);
         chk("pins run", crystal_pins_en_out, xtal_pins_en_in);
         chk("bo run", brownout_protection_en_out, 1);
         chk("periph", periph_clk_en_out, periph_en_in);
         chk("wdt osc", watchdog_osc_en_out, wdt_osc_en_in);
         go <= 1;
         @(negedge core_clk_in) go <= 0;
         @(negedge core_clk_in);
         chk("park", {in_stop_out, primary_osc_en_out, precision_osc_en_out,
            crystal_pins_en_out, sys_clk_en_out, cpu_halt_out, program_counter_hold_out,
            1'b0}, 8'h86);
         chk("idle", periph_clk_en_out, 0);
         wdt_en_in <= 1'($urandom);
         osc_stable_in <= 1;
         repeat (20) @(negedge core_clk_in);
         chk("wdt run", watchdog_unit_run_out, wdt_en_in & wdt_osc_en_in);
         chk("brownout", brownout_protection_en_out, bo_stop_opt_in);
         chk("held", {in_stop_out, sys_clk_en_out}, 2);
         stop_recovery_in <= 1;
         repeat (3) @(negedge core_clk_in);
         stop_recovery_in <= 0;
         for (w = 0; sys_clk_en_out !== 1 && w < 400; w++) @(negedge core_clk_in);
         chk("settle", w >= `SMPC_OSC_SETTLE_CYC && w < 220, 1);
         chk("resume", {in_stop_out, cpu_halt_out, primary_osc_en_out}, 1);
         osc_stable_in <= 0;
         $display("stop and recovery test done");
      end
      final_report();
   end
endmodule : tb_stop_mode_power_control
